// >>> rtl/tcoc_pkg.sv
// package: register map, field positions, reset values and mode encodings
package tcoc_pkg;
   localparam logic [7:0] TCOC_OFS_COMBO = 8'h00;
   localparam logic [7:0] TCOC_OFS_OE    = 8'h04;
   localparam logic [7:0] TCOC_OFS_CTRL  = 8'h08;
   localparam logic [7:0] TCOC_OFS_STAT  = 8'h0C;
   localparam logic [7:0] TCOC_COMBO_RST = 8'hC0;
   localparam logic [7:0] TCOC_OE_RST    = 8'hFF;
   localparam logic [7:0] TCOC_RSVD_MASK = 8'hC0;
   localparam logic [7:0] TCOC_CTRL_RST  = 8'h10;
   localparam int TCOC_SEL_HI = 5;
   localparam int TCOC_SEL_LO = 4;
   localparam int TCOC_EXT_TRIGGER_DISABLE   = 4;
   localparam int TCOC_SYNC_ENABLE_CH3  = 0;
   localparam int TCOC_SYNC_ENABLE_CH4  = 1;
   localparam int TCOC_PM3    = 2;
   localparam int TCOC_PM4    = 3;
   typedef enum logic [1:0] {TCOC_NORMAL, TCOC_COMP, TCOC_RSYNC} tcoc_mode_t;
   typedef enum {TCOC_IDLE, TCOC_WRESP} tcoc_wstate_t;
endpackage

// >>> rtl/tcoc_pin_if.sv
// interface: per-pin timer output request and gated result
`timescale 1ns/1ps
interface tcoc_pin_if;
   logic [5:0] req_en;
   logic [5:0] req_lvl;
   logic [5:0] master_en;
   logic [5:0] out_en;
   logic [5:0] out_lvl;
   modport core (output req_en, output req_lvl, output master_en, input out_en, input out_lvl);
   modport gate (input req_en, input req_lvl, input master_en, output out_en, output out_lvl);
endinterface

// >>> rtl/tcoc_pin_gate.sv
// module: master enable gating of the six timer output pins
`timescale 1ns/1ps
module tcoc_pin_gate (
   input wire logic CLK,
   input wire logic SYS_RST,
   tcoc_pin_if.gate pins
);
   // --------------------------------------------------
   // pin gating
   // --------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : gl
         always_ff @(posedge CLK) begin
            if (SYS_RST) begin
               pins.out_en[g]  <= 1'b0;
               pins.out_lvl[g] <= 1'b0;
            end else begin
               // a cleared enable hands the pin back to general I/O
               pins.out_en[g]  <= pins.master_en[g] & pins.req_en[g];
               pins.out_lvl[g] <= pins.master_en[g] & pins.req_en[g] & pins.req_lvl[g];
            end
         end
      end
   endgenerate

   AST_GATE_OFF: assert property (@(posedge CLK) disable iff (SYS_RST)
      !pins.master_en[0] |=> !pins.out_en[0])
      else $error("pin a ch3 driven while disabled");
endmodule

// >>> rtl/tcoc_top.sv
// module: channel 3/4 combination, buffer select and output master enable
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tcoc_top (
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        STANDBY,
   input  wire logic        CAPTURE_A_CH1,
   input  wire logic [5:0]  PIN_REQ_EN,
   input  wire logic [5:0]  PIN_REQ_LVL,
   output logic      [5:0]  PIN_OUT_EN,
   output logic      [5:0]  PIN_OUT_LVL,
   output logic      [1:0]  COMBO_MODE,
   output logic             PULSE_MODE_CH3_EFF,
   output logic             PULSE_MODE_CH4_EFF,
   output logic             SYNC_ENABLE_CH3_EFF,
   output logic             SYNC_ENABLE_CH4_EFF,
   output logic      [3:0]  BUFFER_SEL,
   input  wire logic [7:0]  AWADDR,
   input  wire logic [2:0]  AWPROT,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic      [1:0]  BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic [2:0]  ARPROT,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic      [31:0] RDATA,
   output logic      [1:0]  RRESP,
   output logic             RVALID,
   input  wire logic        RREADY
);
   // --------------------------------------------------
   // registers
   // --------------------------------------------------
   logic [5:0]  combo_r;
   logic [5:0]  oe_r;
   logic [7:0]  ctrl_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        trig_r;
   logic        wr_fire;
   logic        trig_hit;
   logic        joint_pwm;
   tcoc_pkg::tcoc_mode_t  mode;
   tcoc_pkg::tcoc_wstate_t wst_r;

   // decode of the two-bit combination field
   function automatic tcoc_pkg::tcoc_mode_t tcoc_decode(input logic [1:0] sel);
      case (sel)
         2'b10:   tcoc_decode = tcoc_pkg::TCOC_COMP;
         2'b11:   tcoc_decode = tcoc_pkg::TCOC_RSYNC;
         default: tcoc_decode = tcoc_pkg::TCOC_NORMAL;
      endcase
   endfunction

   assign mode      = tcoc_decode(combo_r[tcoc_pkg::TCOC_SEL_HI:tcoc_pkg::TCOC_SEL_LO]);
   assign joint_pwm = (mode != tcoc_pkg::TCOC_NORMAL);
   // capture trigger only when enabled and in a joint mode
   assign trig_hit  = CAPTURE_A_CH1 & ~ctrl_r[tcoc_pkg::TCOC_EXT_TRIGGER_DISABLE] & joint_pwm;

   // --------------------------------------------------
   // axi4-lite write channel
   // --------------------------------------------------
   assign AWREADY = (wst_r == tcoc_pkg::TCOC_IDLE) & ~aw_got_r;
   assign WREADY  = (wst_r == tcoc_pkg::TCOC_IDLE) & ~w_got_r;
   assign wr_fire = (wst_r == tcoc_pkg::TCOC_IDLE)
                  & (aw_got_r | AWVALID) & (w_got_r | WVALID);

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
         wst_r    <= tcoc_pkg::TCOC_IDLE;
         BVALID   <= 1'b0;
         BRESP    <= 2'b00;
      end else begin
         case (wst_r)
            tcoc_pkg::TCOC_IDLE: begin
               if (AWVALID && AWREADY) begin
                  aw_got_r <= 1'b1;
                  awaddr_r <= AWADDR;
               end
               if (WVALID && WREADY) begin
                  w_got_r <= 1'b1;
                  wdata_r <= WDATA;
                  wstrb_r <= WSTRB;
               end
               if (wr_fire) begin
                  aw_got_r <= 1'b0;
                  w_got_r  <= 1'b0;
                  wst_r    <= tcoc_pkg::TCOC_WRESP;
                  BVALID   <= 1'b1;
                  BRESP    <= 2'b00;
               end
            end
            tcoc_pkg::TCOC_WRESP: begin
               if (BREADY) begin
                  BVALID <= 1'b0;
                  wst_r  <= tcoc_pkg::TCOC_IDLE;
               end
            end
            default: wst_r <= tcoc_pkg::TCOC_IDLE;
         endcase
      end
   end

   // effective write address and data at the firing edge
   logic [7:0] wa;
   logic [7:0] wd;
   logic       wb0;
   assign wa  = aw_got_r ? awaddr_r : AWADDR;
   assign wd  = w_got_r ? wdata_r[7:0] : WDATA[7:0];
   assign wb0 = w_got_r ? wstrb_r[0] : WSTRB[0];

   // --------------------------------------------------
   // combination function control register
   // --------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST || STANDBY) begin
         combo_r <= tcoc_pkg::TCOC_COMBO_RST[5:0];
      end else if (wr_fire && wb0 && wa == tcoc_pkg::TCOC_OFS_COMBO) begin
         combo_r <= wd[5:0];
      end
   end

   // --------------------------------------------------
   // output master enable register
   // --------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST || STANDBY) begin
         oe_r <= tcoc_pkg::TCOC_OE_RST[5:0];
      end else if (trig_hit) begin
         oe_r <= 6'h00;
      end else if (wr_fire && wb0 && wa == tcoc_pkg::TCOC_OFS_OE) begin
         oe_r <= wd[5:0];
      end
   end

   // --------------------------------------------------
   // auxiliary control: trigger disable, sync and pulse mode bits
   // --------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST || STANDBY) begin
         ctrl_r <= tcoc_pkg::TCOC_CTRL_RST;
      end else if (wr_fire && wb0 && wa == tcoc_pkg::TCOC_OFS_CTRL) begin
         ctrl_r <= {3'b000, wd[4:0]};
      end
   end

   // sticky record that the capture trigger fired, cleared by status read
   logic rd_stat;
   always_ff @(posedge CLK) begin
      if (SYS_RST || STANDBY) begin
         trig_r <= 1'b0;
      end else if (trig_hit) begin
         trig_r <= 1'b1;
      end else if (rd_stat) begin
         trig_r <= 1'b0;
      end
   end

   // --------------------------------------------------
   // axi4-lite read channel
   // --------------------------------------------------
   assign ARREADY = ~RVALID;
   assign rd_stat = ARVALID & ARREADY & (ARADDR == tcoc_pkg::TCOC_OFS_STAT);

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         RVALID <= 1'b0;
         RDATA  <= 32'h0000_0000;
         RRESP  <= 2'b00;
      end else if (ARVALID && ARREADY) begin
         RVALID <= 1'b1;
         RRESP  <= 2'b00;
         case (ARADDR)
            tcoc_pkg::TCOC_OFS_COMBO: RDATA <= {24'h00_0000, tcoc_pkg::TCOC_RSVD_MASK[7:6], combo_r};
            tcoc_pkg::TCOC_OFS_OE:    RDATA <= {24'h00_0000, tcoc_pkg::TCOC_RSVD_MASK[7:6], oe_r};
            tcoc_pkg::TCOC_OFS_CTRL:  RDATA <= {24'h00_0000, ctrl_r};
            tcoc_pkg::TCOC_OFS_STAT:  RDATA <= {29'h0000_0000, trig_r, mode};
            default: begin
               RDATA <= 32'h0000_0000;
               RRESP <= 2'b10;
            end
         endcase
      end else if (RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // --------------------------------------------------
   // mode outputs
   // --------------------------------------------------
   assign COMBO_MODE          = mode;
   assign PULSE_MODE_CH3_EFF  = ctrl_r[tcoc_pkg::TCOC_PM3] & ~joint_pwm;
   assign PULSE_MODE_CH4_EFF  = ctrl_r[tcoc_pkg::TCOC_PM4] & ~joint_pwm;
   assign SYNC_ENABLE_CH3_EFF = ctrl_r[tcoc_pkg::TCOC_SYNC_ENABLE_CH3];
   assign SYNC_ENABLE_CH4_EFF = ctrl_r[tcoc_pkg::TCOC_SYNC_ENABLE_CH4];
   assign BUFFER_SEL          = combo_r[3:0];

   // --------------------------------------------------
   // pin gating
   // --------------------------------------------------
   tcoc_pin_if pif ();
   assign pif.req_en    = PIN_REQ_EN;
   assign pif.req_lvl   = PIN_REQ_LVL;
   assign pif.master_en = oe_r;
   assign PIN_OUT_EN    = pif.out_en;
   assign PIN_OUT_LVL   = pif.out_lvl;

   tcoc_pin_gate u_gate (
      .CLK     (CLK),
      .SYS_RST (SYS_RST),
      .pins    (pif.gate)
   );

   // --------------------------------------------------
   // checks
   // --------------------------------------------------
   sequence s_trig;
      CAPTURE_A_CH1 && !ctrl_r[tcoc_pkg::TCOC_EXT_TRIGGER_DISABLE] && joint_pwm && !STANDBY;
   endsequence

   AST_STANDBY_COMBO: assert property (@(posedge CLK) STANDBY |=> combo_r == 6'h00)
      else $error("combo not reset by standby");
   AST_STANDBY_OE: assert property (@(posedge CLK) STANDBY |=> oe_r == 6'h3F)
      else $error("oe not reset by standby");
   AST_TRIG_CLEAR: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_trig |=> oe_r == 6'h00 ##1 PIN_OUT_EN == 6'h00)
      else $error("capture did not shut outputs");
   AST_TRIG_GATED: assert property (@(posedge CLK) disable iff (SYS_RST || STANDBY)
      (!joint_pwm || ctrl_r[tcoc_pkg::TCOC_EXT_TRIGGER_DISABLE]) && !wr_fire |=> oe_r == $past(oe_r))
      else $error("oe changed without cause");
   AST_PM_IGNORED: assert property (@(posedge CLK) disable iff (SYS_RST)
      joint_pwm |-> !PULSE_MODE_CH3_EFF && !PULSE_MODE_CH4_EFF)
      else $error("pulse mode not overridden");
   AST_RSVD_READ: assert property (@(posedge CLK) disable iff (SYS_RST)
      ARVALID && ARREADY && ARADDR == tcoc_pkg::TCOC_OFS_OE |=> RVALID && RDATA[7:6] == 2'b11)
      else $error("reserved bits not one");
   AST_DECODE: assert property (@(posedge CLK) disable iff (SYS_RST)
      combo_r[5:4] == 2'b11 |-> COMBO_MODE == 2'd2)
      else $error("bad mode decode");
   AST_BUF: assert property (@(posedge CLK) disable iff (SYS_RST || STANDBY)
      wr_fire && wb0 && wa == tcoc_pkg::TCOC_OFS_COMBO |=> BUFFER_SEL == $past(wd[3:0]))
      else $error("buffer select not written");
   AST_SYNC: assert property (@(posedge CLK) disable iff (SYS_RST)
      joint_pwm && ctrl_r[0] |-> SYNC_ENABLE_CH3_EFF)
      else $error("sync lost in joint mode");
endmodule

// >>> verification/tcoc_pin_model.sv
// partner model: timer pin requests and channel 1 capture trigger
`timescale 1ns/1ps
module tcoc_pin_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       fire,
   input  wire logic [5:0] en_in,
   input  wire logic [5:0] lvl_in,
   output logic      [5:0] req_en,
   output logic      [5:0] req_lvl,
   output logic            capture
);
   logic [5:0] en_r;
   logic [5:0] lvl_r;
   logic       cap_r;
   // one-cycle capture event per request, pin wishes launched off the edge
   always_ff @(posedge clk) begin
      if (rst) begin
         en_r  <= 6'h00;
         lvl_r <= 6'h00;
         cap_r <= 1'b0;
      end else begin
         en_r  <= en_in;
         lvl_r <= lvl_in;
         cap_r <= fire;
      end
   end
   assign req_en  = en_r;
   assign req_lvl = lvl_r;
   assign capture = cap_r;
endmodule

// >>> verification/timer_ch34_combination_output_ctrl_bench.sv
// testbench: register bus, mode decode, pin gating, trigger and standby
`timescale 1ns/1ps
module timer_ch34_combination_output_ctrl_bench;
   logic CLK = 0, SYS_RST = 1, STANDBY = 0, fire = 0, cap;
   logic [5:0] req_en, req_lvl, en_in = 0, lvl_in = 0, out_en, out_lvl;
   logic [1:0] mode, bresp, rresp;
   logic pm3, pm4, sy3, sy4, awready, wready, bvalid, arready, rvalid;
   logic [3:0] bsel;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [7:0] w, c;
   logic [1:0] r, s;
   int err_count = 0, tests_run = 0, seed = 79;
   always #20 CLK = ~CLK;
   tcoc_pin_model PM (.clk(CLK), .rst(SYS_RST), .fire(fire), .en_in(en_in), .lvl_in(lvl_in),
      .req_en(req_en), .req_lvl(req_lvl), .capture(cap));
   tcoc_top DUT (.CLK(CLK), .SYS_RST(SYS_RST), .STANDBY(STANDBY), .CAPTURE_A_CH1(cap),
      .PIN_REQ_EN(req_en), .PIN_REQ_LVL(req_lvl), .PIN_OUT_EN(out_en), .PIN_OUT_LVL(out_lvl),
      .COMBO_MODE(mode), .PULSE_MODE_CH3_EFF(pm3), .PULSE_MODE_CH4_EFF(pm4),
      .SYNC_ENABLE_CH3_EFF(sy3), .SYNC_ENABLE_CH4_EFF(sy4), .BUFFER_SEL(bsel),
      .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
      .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
   task automatic give_verdict;
      $display("compares %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // handshakes are judged at the falling edge, where ready is settled
   task automatic axw(input logic [7:0] a, input logic [7:0] v);
      logic ha, hw, hb;
      logic [1:0] bs;
      hb = 0;
      bs = 2'h0;
      // one edge between transfers so no strobe is assigned twice in a step
      @(posedge CLK);
      awaddr <= a;
      wdata <= {24'h00_0000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!hb) begin
         @(negedge CLK);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid === 1'b1;
         bs = bresp;
         @(posedge CLK);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end
      chk(bs, 2'h0); // every write is answered okay
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
      logic ha, hr;
      hr = 0;
      rs = 2'h0;
      @(posedge CLK);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!hr) begin
         @(negedge CLK);
         ha = arvalid & arready;
         hr = rvalid === 1'b1;
         dv = rdata;
         rs = rresp;
         @(posedge CLK);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end
      // only the four aligned offsets up to status are mapped
      chk(rs, (a[1:0] == 2'h0 && a <= tcoc_pkg::TCOC_OFS_STAT) ? 2'h0 : 2'h2);
   endtask
   function automatic logic [1:0] exp_mode(input logic [1:0] s);
      return (s == 2'h2) ? 2'h1 : (s == 2'h3) ? 2'h2 : 2'h0;
   endfunction
   initial begin
      repeat (20000) @(posedge CLK);
      err_count++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge CLK);
      SYS_RST <= 1'b0;
      @(posedge CLK);
      axr(tcoc_pkg::TCOC_OFS_COMBO, d, r);
      chk(d, 32'h0000_00C0);
      chk({mode, bsel}, 6'h00);
      axr(tcoc_pkg::TCOC_OFS_OE, d, r);
      chk(d, 32'h0000_00FF);
      axr(tcoc_pkg::TCOC_OFS_CTRL, d, r);
      chk(d, 32'h0000_0010);
      for (int i = 0; i < 12; i++) begin
         w = 8'($random(seed));
         w[5:4] = i[1:0];
         c = 8'($random(seed));
         c[4] = 1'b1;
         // ctrl is written while the previous or next mode may be complementary
         if (i[1]) c[1] = c[1] & ~c[0];
         axw(tcoc_pkg::TCOC_OFS_CTRL, c);
         axw(tcoc_pkg::TCOC_OFS_COMBO, w); // capture input held idle meanwhile
         axr(tcoc_pkg::TCOC_OFS_COMBO, d, r);
         chk(d, {24'h00_0000, 2'h3, w[5:0]});
         chk(mode, exp_mode(w[5:4]));
         chk(bsel, w[3:0]);
         chk({pm4, pm3}, c[3:2] & {2{~w[5]}});
         chk({sy4, sy3}, c[1:0]);
      end
      for (int i = 0; i < 6; i++) begin
         w = 8'($random(seed));
         w[i] = 1'b0;
         en_in <= 6'($random(seed));
         lvl_in <= 6'($random(seed));
         axw(tcoc_pkg::TCOC_OFS_OE, w);
         axr(tcoc_pkg::TCOC_OFS_OE, d, r);
         chk(d, {24'h00_0000, 2'h3, w[5:0]});
         chk(out_en, en_in & w[5:0]);
         chk(out_lvl, lvl_in & en_in & w[5:0]);
      end
      for (int i = 0; i < 4; i++) begin
         s = (i == 3) ? 2'h0 : (i == 1) ? 2'h3 : 2'h2;
         axw(tcoc_pkg::TCOC_OFS_OE, 8'hFF);
         axw(tcoc_pkg::TCOC_OFS_COMBO, {2'h0, s, 4'h0});
         axw(tcoc_pkg::TCOC_OFS_CTRL, {3'h0, i == 2, 4'h0});
         fire <= 1'b1;
         @(posedge CLK);
         fire <= 1'b0;
         repeat (3) @(posedge CLK);
         axr(tcoc_pkg::TCOC_OFS_OE, d, r);
         chk(d, (i < 2) ? 32'h0000_00C0 : 32'h0000_00FF);
         // status shows the sticky trigger record and the decoded mode
         axr(tcoc_pkg::TCOC_OFS_STAT, d, r);
         chk(d, {29'h0000_0000, i < 2, exp_mode(s)});
      end
      axw(tcoc_pkg::TCOC_OFS_COMBO, 8'h3F);
      axw(tcoc_pkg::TCOC_OFS_OE, 8'h00);
      STANDBY <= 1'b1;
      @(posedge CLK);
      STANDBY <= 1'b0;
      @(posedge CLK);
      axr(tcoc_pkg::TCOC_OFS_COMBO, d, r);
      chk(d, 32'h0000_00C0);
      axr(tcoc_pkg::TCOC_OFS_OE, d, r);
      chk(d, 32'h0000_00FF);
      axr(tcoc_pkg::TCOC_OFS_CTRL, d, r);
      chk(d, 32'h0000_0010);
      axr(8'h10, d, r);
      chk(d, 32'h0000_0000);
      chk(r, 2'h2);
      give_verdict();
   end
endmodule
